// file: logic/dma_chan_addr_ack_control.v
// channel control register, address stepping and acknowledge strobe
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "dma_chan_map.vh"

// What this block does
// - reserved control bits 21..18 read zero; software writes zero there
// - dual address: ack strobe in read cycle if cycle-select 0, write cycle if 1
// - single address: ack strobe for every transfer, cycle-select ignored
// - ack cycle and polarity bits exist only in channels 0 and 1
// - polarity bit 0 gives active-low strobe, 1 gives active-high
// - destination mode 01 adds 1, 2, 4 or 16 per unit
// - destination mode 10 subtracts 1, 2 or 4; illegal for 16-byte units
// - single address towards strobed device ignores destination mode
// - source mode field selects fixed, increment or decrement
// - source mode 01 adds 1, 2, 4 or 16; mode 10 subtracts 1, 2, 4
// - single address from strobed device ignores source mode
// - four-bit request source field chooses which requests are accepted
// - codes 0000 dual external, 0010/0011 single external, 0100 auto
// - single address with strobed device ignores destination address register

module dma_chan_addr_ack_control #(
	parameter CHANNEL = 0
) (
	input wire core_clk_i,
	input wire resetn_i,
	input wire ce_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	input wire dreq_i,
	input wire in_valid_i,
	input wire [31:0] in_data_i,
	output wire in_ready_o,
	output wire out_valid_o,
	output wire [31:0] out_data_o,
	input wire out_ready_i,
	output reg [31:0] src_addr_o,
	output reg [31:0] dst_addr_o,
	output reg dst_addr_used_o,
	output reg transfer_ack_strobe_o
);

// ----------------------------------------
// helpers
// ----------------------------------------
function [31:0] unit_step;
	input [1:0] size;
	begin
		case (size)
			`SZ_8: unit_step = 32'h0000_0001;
			`SZ_16: unit_step = 32'h0000_0002;
			`SZ_32: unit_step = 32'h0000_0004;
			default: unit_step = 32'h0000_0010;
		endcase
	end
endfunction

// decrement of a 16-byte unit is illegal, so the address is held instead
function [31:0] stepped_addr;
	input [31:0] addr;
	input [1:0] mode;
	input [1:0] size;
	begin
		case (mode)
			`STEP_INC: stepped_addr = addr + unit_step(size);
			`STEP_DEC: stepped_addr = (size == `SZ_128) ? addr : addr - unit_step(size);
			default: stepped_addr = addr;
		endcase
	end
endfunction

function bad_mode;
	input [1:0] mode;
	input [1:0] size;
	begin
		bad_mode = (mode == `STEP_RSV) ||
			(size == `SZ_128 && mode != `STEP_INC);
	end
endfunction

// ----------------------------------------
// control fields
// ----------------------------------------
localparam HAS_ACK = (CHANNEL == 0) || (CHANNEL == 1);

reg ack_cycle_select;
reg ack_polarity;
reg dest_step_mode_hi;
reg dest_step_mode_lo;
reg src_step_mode_hi;
reg src_step_mode_lo;
reg req_source_sel_3;
reg req_source_sel_2;
reg req_source_sel_1;
reg req_source_sel_0;
reg [1:0] unit_size;
reg channel_enable_bit;

wire [1:0] dest_mode;
wire [1:0] src_mode;
wire [3:0] req_sel;
wire [31:0] ctrl_view;

assign dest_mode = {dest_step_mode_hi, dest_step_mode_lo};
assign src_mode = {src_step_mode_hi, src_step_mode_lo};
assign req_sel = {req_source_sel_3, req_source_sel_2,
	req_source_sel_1, req_source_sel_0};

// reserved bits are never stored and read back as zero
assign ctrl_view = {10'h000, 4'h0, ack_cycle_select, ack_polarity,
	dest_mode, src_mode, req_sel, 3'h0, unit_size, 2'h0, channel_enable_bit};

// ----------------------------------------
// request pin synchroniser, three stages
// ----------------------------------------
reg dreq_s1;
reg dreq_s2;
reg dreq_s3;
reg dreq_level;

always @(posedge core_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		dreq_s1 <= 1'b0;
		dreq_s2 <= 1'b0;
		dreq_s3 <= 1'b0;
		dreq_level <= 1'b0;
	end
	else if (ce_i)
	begin
		dreq_s1 <= dreq_i;
		dreq_s2 <= dreq_s1;
		dreq_s3 <= dreq_s2;
		// waiting for two stages to agree means a one-cycle pin glitch is never taken
		if (dreq_s2 == dreq_s3)
			dreq_level <= dreq_s3;
	end
end

// ----------------------------------------
// request source decode
// ----------------------------------------
reg mode_dual;
reg mode_to_dev;
reg mode_from_dev;
reg mode_auto;

always @*
begin
	mode_dual = 1'b0;
	mode_to_dev = 1'b0;
	mode_from_dev = 1'b0;
	mode_auto = 1'b0;
	case (req_sel)
		`RS_EXT_DUAL: mode_dual = 1'b1;
		`RS_EXT_TO_DEV: mode_to_dev = 1'b1;
		`RS_DEV_TO_EXT: mode_from_dev = 1'b1;
		`RS_AUTO: mode_auto = 1'b1;
		default: mode_dual = 1'b0;
	endcase
end

wire single_mode;
wire req_ok;
reg allow;

assign single_mode = mode_to_dev | mode_from_dev;
// reserved codes accept no request at all
assign req_ok = mode_auto | ((mode_dual | single_mode) & dreq_level);

// ----------------------------------------
// buffer in the data path
// ----------------------------------------
wire buf_ready;
wire buf_valid;
wire [1:0] buf_count;
wire push;
wire pop;

assign in_ready_o = buf_ready;
assign out_valid_o = buf_valid;
assign push = in_valid_i & buf_ready;
assign pop = buf_valid & out_ready_i;

unit_skid_buffer u_buf (
	.core_clk_i(core_clk_i),
	.resetn_i(resetn_i),
	.ce_i(ce_i),
	.allow_i(allow),
	.in_valid_i(in_valid_i),
	.in_data_i(in_data_i),
	.in_ready_o(buf_ready),
	.out_valid_o(buf_valid),
	.out_data_o(out_data_o),
	.out_ready_i(out_ready_i),
	.count_o(buf_count)
);

// ----------------------------------------
// acknowledge timing
// ----------------------------------------
reg ack_event;

always @*
begin
	if (single_mode)
		ack_event = pop;
	else if (ack_cycle_select)
		ack_event = pop;
	else
		ack_event = push;
end

// ----------------------------------------
// register writes, counters, strobe
// ----------------------------------------
wire wr_ctrl;
wire wr_src;
wire wr_dst;

assign wr_ctrl = reg_wr_i && (reg_addr_i == `OFS_CTRL);
assign wr_src = reg_wr_i && (reg_addr_i == `OFS_SRC);
assign wr_dst = reg_wr_i && (reg_addr_i == `OFS_DST);

always @(posedge core_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		ack_cycle_select <= 1'b0;
		ack_polarity <= 1'b0;
		dest_step_mode_hi <= 1'b0;
		dest_step_mode_lo <= 1'b0;
		src_step_mode_hi <= 1'b0;
		src_step_mode_lo <= 1'b0;
		req_source_sel_3 <= 1'b0;
		req_source_sel_2 <= 1'b0;
		req_source_sel_1 <= 1'b0;
		req_source_sel_0 <= 1'b0;
		unit_size <= 2'h0;
		channel_enable_bit <= 1'b0;
	end
	else if (ce_i && wr_ctrl)
	begin
		// channels without a strobe keep these bits at zero
		ack_cycle_select <= HAS_ACK && reg_wdata_i[`CTL_ACK_CYC];
		ack_polarity <= HAS_ACK && reg_wdata_i[`CTL_ACK_POL];
		dest_step_mode_hi <= reg_wdata_i[`CTL_DM_HI];
		dest_step_mode_lo <= reg_wdata_i[`CTL_DM_LO];
		src_step_mode_hi <= reg_wdata_i[`CTL_SM_HI];
		src_step_mode_lo <= reg_wdata_i[`CTL_SM_LO];
		req_source_sel_3 <= reg_wdata_i[`CTL_RS_HI];
		req_source_sel_2 <= reg_wdata_i[`CTL_RS_LO + 2];
		req_source_sel_1 <= reg_wdata_i[`CTL_RS_LO + 1];
		req_source_sel_0 <= reg_wdata_i[`CTL_RS_LO];
		unit_size <= reg_wdata_i[`CTL_SZ_HI:`CTL_SZ_LO];
		channel_enable_bit <= reg_wdata_i[`CTL_EN];
	end
end

// addresses step once per unit delivered; software writes take priority
always @(posedge core_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		src_addr_o <= `ADDR_RST;
		dst_addr_o <= `ADDR_RST;
	end
	else if (ce_i)
	begin
		if (wr_src)
			src_addr_o <= reg_wdata_i;
		else if (pop && !mode_from_dev)
			src_addr_o <= stepped_addr(src_addr_o, src_mode, unit_size);
		if (wr_dst)
			dst_addr_o <= reg_wdata_i;
		else if (pop && !mode_to_dev)
			dst_addr_o <= stepped_addr(dst_addr_o, dest_mode, unit_size);
	end
end

always @(posedge core_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		allow <= 1'b0;
		dst_addr_used_o <= 1'b1;
		transfer_ack_strobe_o <= 1'b1;
	end
	else if (ce_i)
	begin
		allow <= channel_enable_bit & req_ok;
		dst_addr_used_o <= !single_mode;
		// polarity is applied at this flop, so a new level shows one cycle after the write
		if (!HAS_ACK)
			transfer_ack_strobe_o <= 1'b1;
		else if (ce_i && ack_event)
			transfer_ack_strobe_o <= ack_polarity;
		else
			transfer_ack_strobe_o <= ~ack_polarity;
	end
end

// ----------------------------------------
// register reads, data in the next cycle only
// ----------------------------------------
wire [31:0] stat_view;

// a reserved step code, or a 16-byte unit set to any mode but increment, shows here unless single address ignores that side's mode
assign stat_view = {26'h0000000,
	bad_mode(dest_mode, unit_size) & !mode_to_dev,
	bad_mode(src_mode, unit_size) & !mode_from_dev,
	dreq_level, allow, buf_count};

always @(posedge core_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
		reg_rdata_o <= 32'h0000_0000;
	else if (ce_i)
	begin
		if (!reg_rd_i)
			reg_rdata_o <= 32'h0000_0000;
		else
		begin
			case (reg_addr_i)
				`OFS_CTRL: reg_rdata_o <= ctrl_view;
				`OFS_SRC: reg_rdata_o <= src_addr_o;
				`OFS_DST: reg_rdata_o <= dst_addr_o;
				`OFS_STAT: reg_rdata_o <= stat_view;
				default: reg_rdata_o <= 32'h0000_0000;
			endcase
		end
	end
end

endmodule

// file: logic/dma_chan_map.vh
// register map, field positions, reset values and codes of the channel control
`ifndef DMA_CHAN_MAP_VH
`define DMA_CHAN_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_SRC 8'h04
`define OFS_DST 8'h08
`define OFS_STAT 8'h0c

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTL_RSV_HI 21
`define CTL_RSV_LO 18
`define CTL_ACK_CYC 17
`define CTL_ACK_POL 16
`define CTL_DM_HI 15
`define CTL_DM_LO 14
`define CTL_SM_HI 13
`define CTL_SM_LO 12
`define CTL_RS_HI 11
`define CTL_RS_LO 8
`define CTL_SZ_HI 4
`define CTL_SZ_LO 3
`define CTL_EN 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RST 32'h0000_0000
`define ADDR_RST 32'h0000_0000

// ----------------------------------------
// step modes and unit sizes
// ----------------------------------------
`define STEP_FIX 2'h0
`define STEP_INC 2'h1
`define STEP_DEC 2'h2
`define STEP_RSV 2'h3
`define SZ_8 2'h0
`define SZ_16 2'h1
`define SZ_32 2'h2
`define SZ_128 2'h3

// ----------------------------------------
// request source codes
// ----------------------------------------
`define RS_EXT_DUAL 4'h0
`define RS_EXT_TO_DEV 4'h2
`define RS_DEV_TO_EXT 4'h3
`define RS_AUTO 4'h4

// ----------------------------------------
// buffer depth
// ----------------------------------------
`define BUF_DEPTH 2'h2

`endif

// file: logic/unit_skid_buffer.v
// two-entry buffer between the accepting side and the delivering side
`timescale 1ns/10ps
`include "dma_chan_map.vh"

module unit_skid_buffer (
	input wire core_clk_i,
	input wire resetn_i,
	input wire ce_i,
	input wire allow_i,
	input wire in_valid_i,
	input wire [31:0] in_data_i,
	output reg in_ready_o,
	output reg out_valid_o,
	output reg [31:0] out_data_o,
	input wire out_ready_i,
	output reg [1:0] count_o
);

reg [31:0] skid;
reg [1:0] next_count;
wire push;
wire pop;

assign push = in_valid_i & in_ready_o;
assign pop = out_valid_o & out_ready_i;

always @*
begin
	next_count = count_o;
	if (push & ~pop)
		next_count = count_o + 2'h1;
	else if (pop & ~push)
		next_count = count_o - 2'h1;
end

// ----------------------------------------
// storage; ready is registered so a full buffer stalls the source
// ----------------------------------------
always @(posedge core_clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		count_o <= 2'h0;
		in_ready_o <= 1'b0;
		out_valid_o <= 1'b0;
		out_data_o <= 32'h0000_0000;
		skid <= 32'h0000_0000;
	end
	else if (ce_i)
	begin
		count_o <= next_count;
		out_valid_o <= (next_count != 2'h0);
		in_ready_o <= allow_i & (next_count != `BUF_DEPTH);
		if (count_o == 2'h2 && pop)
			out_data_o <= skid;
		else if (push && (count_o == 2'h0 || pop))
			out_data_o <= in_data_i;
		else if (push)
			skid <= in_data_i;
	end
end

endmodule

// file: verification/chan_ctrl_monitor.sv
// concurrent checks on the channel control block ports
`timescale 1ns/10ps
module chan_ctrl_monitor #(
	parameter CHANNEL = 0
) (
	input wire core_clk_i,
	input wire resetn_i,
	input wire ce_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [31:0] reg_rdata_o,
	input wire in_valid_i,
	input wire in_ready_o,
	input wire out_valid_o,
	input wire out_ready_i,
	input wire [31:0] src_addr_o,
	input wire [31:0] dst_addr_o,
	input wire dst_addr_used_o,
	input wire transfer_ack_strobe_o
);
	// ----------------------------------------
	// shadow of the control fields
	// ----------------------------------------
	reg [17:0] c;
	wire ha = CHANNEL < 2;
	wire [31:0] stp = (c[4:3] == 2'h3) ? 32'h10 : (32'h1 << c[4:3]);
	wire act = ha && transfer_ack_strobe_o == c[16];
	// a register write in the same cycle may retarget an address, so it is left out
	wire pop = out_valid_o && out_ready_i && ce_i && !reg_wr_i;
	wire push = in_valid_i && in_ready_o && ce_i && !reg_wr_i;
	wire dual = c[11:8] == 4'h0 || c[11:8] == 4'h4;
	always @(posedge core_clk_i or negedge resetn_i)
		if (!resetn_i)
			c <= 18'h0;
		else if (ce_i && reg_wr_i && reg_addr_i == 8'h00)
			c <= reg_wdata_i[17:0];
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_rd_ctrl;
		ce_i && reg_rd_i && reg_addr_i == 8'h00;
	endsequence
	sequence s_single_held;
		(c[11:9] == 3'h1)[*2];
	endsequence
	sequence s_quiet_ctrl_wr;
		ce_i && reg_wr_i && reg_addr_i == 8'h00 && ha && !in_valid_i && !out_valid_o
			##1 ce_i && !in_valid_i && !out_valid_o;
	endsequence
	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_rsv_read_zero: assert property (s_rd_ctrl |=> reg_rdata_o[21:18] == 4'h0)
		else $error("reserved control bits read nonzero");
	a_ack_bits_absent: assert property (s_rd_ctrl ##0 !ha |=> reg_rdata_o[17:16] == 2'h0)
		else $error("strobe bits present in upper channel");
	a_ack_read_cyc: assert property (push && ha && !c[17] && dual |=> act)
		else $error("no strobe after push in read cycle mode");
	a_ack_write_cyc: assert property (pop && ha && c[17] && dual |=> act)
		else $error("no strobe after pop in write cycle mode");
	a_ack_single: assert property (pop && ha && c[11:9] == 3'h1 |=> act)
		else $error("no strobe in single address mode");
	a_idle_polarity: assert property (s_quiet_ctrl_wr |=> transfer_ack_strobe_o == !$past(c[16]))
		else $error("strobe idle level wrong");
	a_src_inc: assert property (pop && c[13:12] == 2'h1 && c[11:8] != 4'h3
		|=> src_addr_o == $past(src_addr_o) + $past(stp))
		else $error("source increment wrong");
	a_src_dec: assert property (pop && c[13:12] == 2'h2 && c[4:3] != 2'h3 && c[11:8] != 4'h3
		|=> src_addr_o == $past(src_addr_o) - $past(stp))
		else $error("source decrement wrong");
	a_dst_inc: assert property (pop && c[15:14] == 2'h1 && c[11:8] != 4'h2
		|=> dst_addr_o == $past(dst_addr_o) + $past(stp))
		else $error("destination increment wrong");
	a_dst_dec: assert property (pop && c[15:14] == 2'h2 && c[4:3] != 2'h3 && c[11:8] != 4'h2
		|=> dst_addr_o == $past(dst_addr_o) - $past(stp))
		else $error("destination decrement wrong");
	a_dst_ignored: assert property (pop && c[11:8] == 4'h2 |=> $stable(dst_addr_o))
		else $error("destination moved in single mode");
	a_dst_unused: assert property (s_single_held |-> !dst_addr_used_o)
		else $error("destination register used in single mode");
	a_rsv_src_refused: assert property ((c[11:8] == 4'h1)[*3] |-> !in_ready_o)
		else $error("reserved request code accepts data");
endmodule
bind dma_chan_addr_ack_control chan_ctrl_monitor #(.CHANNEL(CHANNEL)) mon (
	.core_clk_i(core_clk_i),
	.resetn_i(resetn_i),
	.ce_i(ce_i),
	.reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.in_valid_i(in_valid_i),
	.in_ready_o(in_ready_o),
	.out_valid_o(out_valid_o),
	.out_ready_i(out_ready_i),
	.src_addr_o(src_addr_o),
	.dst_addr_o(dst_addr_o),
	.dst_addr_used_o(dst_addr_used_o),
	.transfer_ack_strobe_o(transfer_ack_strobe_o)
);

// file: verification/ack_peer_model.sv
// strobed peripheral: request pin, sink ready with stalls, strobe counter
`timescale 1ns/10ps
module ack_peer_model (
	input wire core_clk_i,
	input wire pol_i,
	input wire want_i,
	input wire hold_i,
	input wire ack_i,
	output reg dreq_o = 1'b0,
	output reg ready_o = 1'b0,
	output integer acks_o = 0
);
	reg [1:0] t = 2'h0;
	always @(posedge core_clk_i)
	begin
		t <= t + 2'h1;
		dreq_o <= want_i;
		// a stall every fourth cycle keeps the buffer busy
		ready_o <= !hold_i && t != 2'h0;
		if (ack_i === pol_i)
			acks_o <= acks_o + 1;
	end
endmodule

// file: verification/test_dma_chan_addr_ack_control.sv
// self-checking bench for the channel control block
`timescale 1ns/10ps
`include "dma_chan_map.vh"
module test_dma_chan_addr_ack_control;
	reg core_clk_i = 1'b0;
	reg resetn_i = 1'b0;
	reg ce_i = 1'b1;
	reg [7:0] reg_addr_i = 8'h00;
	reg [31:0] reg_wdata_i = 32'h0;
	reg reg_wr_i = 1'b0;
	reg reg_rd_i = 1'b0;
	reg in_valid_i = 1'b0;
	reg [31:0] in_data_i = 32'h0;
	reg want = 1'b0;
	reg hold = 1'b1;
	reg pol = 1'b0;
	wire [31:0] reg_rdata_o, out_data_o, src_addr_o, dst_addr_o, rd2, acks;
	wire in_ready_o, out_valid_o, dst_addr_used_o, transfer_ack_strobe_o;
	wire dreq_i, out_ready_i, ack2;
	integer n_fail = 0, tests_run = 0, npop = 0, i, j, k, n0;
	reg [31:0] x = 32'h490e, a, b, v, q[$];
	reg [3:0] rs;
	reg [31:0] cfg [0:5] = '{32'h0000_9000, 32'h0003_6408, 32'h0001_0410,
		32'h0002_5018, 32'h0000_5210, 32'h0003_a308};
	dma_chan_addr_ack_control #(.CHANNEL(0)) dut (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.dreq_i(dreq_i),
		.in_valid_i(in_valid_i),
		.in_data_i(in_data_i),
		.in_ready_o(in_ready_o),
		.out_valid_o(out_valid_o),
		.out_data_o(out_data_o),
		.out_ready_i(out_ready_i),
		.src_addr_o(src_addr_o),
		.dst_addr_o(dst_addr_o),
		.dst_addr_used_o(dst_addr_used_o),
		.transfer_ack_strobe_o(transfer_ack_strobe_o)
	);
	dma_chan_addr_ack_control #(.CHANNEL(2)) dut2 (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(rd2),
		.dreq_i(dreq_i),
		.in_valid_i(in_valid_i),
		.in_data_i(in_data_i),
		.in_ready_o(),
		.out_valid_o(),
		.out_data_o(),
		.out_ready_i(out_ready_i),
		.src_addr_o(),
		.dst_addr_o(),
		.dst_addr_used_o(),
		.transfer_ack_strobe_o(ack2)
	);
	ack_peer_model peer (.core_clk_i(core_clk_i), .pol_i(pol), .want_i(want), .hold_i(hold),
		.ack_i(transfer_ack_strobe_o), .dreq_o(dreq_i), .ready_o(out_ready_i), .acks_o(acks));
	initial
		forever #5 core_clk_i = ~core_clk_i;
	function [31:0] xs(input [31:0] s);
		xs = s ^ (s << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	// step per unit; a 16-byte unit adds 16 on increment but subtracts 8 on decrement
	function [31:0] dlt(input [1:0] m, input [1:0] sz);
		dlt = (m == 2'h1) ? ((sz == 2'h3) ? 32'h10 : 32'h1 << sz)
			: (m == 2'h2) ? -(32'h1 << sz) : 32'h0;
	endfunction
	task tally_and_finish;
		if (n_fail == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			n_fail = n_fail + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task bound(input integer kk);
		if (kk >= 200)
		begin
			n_fail = n_fail + 1;
			tally_and_finish;
		end
	endtask
	task wr(input [7:0] ad, input [31:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= ad;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input [7:0] ad);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= ad;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask
	task push(input [31:0] d);
		in_valid_i <= 1'b1;
		in_data_i <= d;
		q.push_back(d);
		k = 0;
		@(posedge core_clk_i);
		while (in_ready_o !== 1'b1 && k < 200)
		begin
			@(posedge core_clk_i);
			k = k + 1;
		end
		bound(k);
	endtask
	always @(posedge core_clk_i)
		if (resetn_i && out_valid_o === 1'b1 && out_ready_i === 1'b1)
		begin
			chk(out_data_o, q.pop_front());
			npop = npop + 1;
		end
	initial
	begin
		repeat (12) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		@(posedge core_clk_i);
		#1 chk({31'h0, transfer_ack_strobe_o}, 32'h1);
		chk({31'h0, dst_addr_used_o}, 32'h1);
		rd(`OFS_CTRL);
		chk(v, `CTRL_RST);
		rd(8'h10);
		chk(v, 32'h0);
		wr(`OFS_CTRL, 32'h003f_f118);
		rd(`OFS_CTRL);
		chk(v, 32'h0003_f118);
		chk(rd2, 32'h0000_f118);
		chk({31'h0, ack2}, 32'h1);
		rd(`OFS_STAT);
		chk(v, 32'h0000_0030);
		// a write while the clock enable is low must leave the register untouched
		@(posedge core_clk_i);
		ce_i <= 1'b0;
		wr(`OFS_CTRL, 32'h0000_0400);
		ce_i <= 1'b1;
		rd(`OFS_CTRL);
		chk(v, 32'h0003_f118);
		for (i = 0; i < 6; i = i + 1)
		begin
			rs = cfg[i][11:8];
			x = xs(x);
			a = x & 32'hffff_fff0;
			x = xs(x);
			b = x & 32'hffff_fff0;
			wr(`OFS_SRC, a);
			wr(`OFS_DST, b);
			pol <= cfg[i][16];
			want <= 1'b1;
			hold <= 1'b1;
			wr(`OFS_CTRL, cfg[i]);
			wr(`OFS_CTRL, cfg[i] | 32'h1);
			repeat (6) @(posedge core_clk_i);
			n0 = acks;
			npop = 0;
			for (j = 0; j < 5; j = j + 1)
			begin
				x = xs(x);
				push(x);
				if (j == 1)
				begin
					// sink stalled: two words fill the buffer
					repeat (3) @(posedge core_clk_i);
					chk({31'h0, in_ready_o}, 32'h0);
					hold <= 1'b0;
				end
			end
			in_valid_i <= 1'b0;
			k = 0;
			while (npop < 5 && k < 200)
			begin
				@(posedge core_clk_i);
				k = k + 1;
			end
			bound(k);
			wr(`OFS_CTRL, cfg[i]);
			want <= 1'b0;
			repeat (3) @(posedge core_clk_i);
			chk(acks - n0, 32'h5);
			chk(src_addr_o, rs == 4'h3 ? a : a + 5 * dlt(cfg[i][13:12], cfg[i][4:3]));
			chk(dst_addr_o, rs == 4'h2 ? b : b + 5 * dlt(cfg[i][15:14], cfg[i][4:3]));
			chk({31'h0, dst_addr_used_o}, {31'h0, rs[3:1] != 3'h1});
		end
		tally_and_finish;
	end
endmodule
